// *** afc_defs.svh ***
// constants for the host controller of an 8k x 9 asynchronous fifo device
// assumes one 125 MHz system clock; device pins are asynchronous to it
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH
`define AFC_WIDTH 9
`define AFC_DEPTH 8192
`define AFC_PTR_W 14
`define AFC_ADDR_W 4
// register offsets
`define AFC_REG_CTRL 4'h0
`define AFC_REG_STAT 4'h1
`define AFC_REG_WDATA 4'h2
`define AFC_REG_RDATA 4'h3
`define AFC_REG_COUNT 4'h4
// control fields
`define AFC_CTRL_CHAIN 0
`define AFC_CTRL_FIRST 1
`define AFC_CTRL_RESET 2
`define AFC_CTRL_REPLAY 3
// strobe timing: low pulse width and recovery, in ns
`define AFC_PULSE_NS 35
`define AFC_RECOV_NS 15
`define AFC_CLK_NS 8
`define AFC_PULSE_CYC ((`AFC_PULSE_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_RECOV_CYC ((`AFC_RECOV_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_CNT_W 4
`endif

// *** afc_pkg.sv ***
// types for the fifo device host controller
// assumes afc_defs.svh is on the include path
package afc_pkg;
`include "afc_defs.svh"
   // strobe sequencer states, gray along idle-low-recover
   typedef enum logic [1:0] {
      AFC_IDLE = 2'b00,
      AFC_LOW = 2'b01,
      AFC_RECOV = 2'b11
   } afc_state_t;
endpackage

// *** afc_strobe_if.sv ***
// carrier between the host top and one strobe sequencer
// assumes both ends share clk_sys
`timescale 1ns/10ps
interface afc_strobe_if;
   logic start;
   logic busy;
   logic strobeN;
   modport host (output start, input busy, input strobeN);
   modport seq (input start, output busy, output strobeN);
endinterface

// *** afc_strobe_seq.sv ***
// one active-low request strobe generator with minimum low and recovery times
// assumes start is a single-cycle pulse given only while busy is low
`timescale 1ns/10ps
`include "afc_defs.svh"
module afc_strobe_seq
   import afc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clkEn,
   afc_strobe_if.seq sq
);
   afc_state_t state_q;
   logic [`AFC_CNT_W-1:0] cnt_q;
   // sequencer: strobe low for the pulse count, then high for recovery
   // request strobe pulse
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= AFC_IDLE;
         cnt_q <= '0;
      end
      else if (clkEn)
      begin
         case (state_q)
            AFC_IDLE:
            begin
               if (sq.start)
               begin
                  state_q <= AFC_LOW;
                  cnt_q <= `AFC_CNT_W'(`AFC_PULSE_CYC - 1);
               end
            end
            AFC_LOW:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= AFC_RECOV;
                  cnt_q <= `AFC_CNT_W'(`AFC_RECOV_CYC - 1);
               end
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            AFC_RECOV:
            begin
               if (cnt_q == '0)
                  state_q <= AFC_IDLE;
               else
                  cnt_q <= cnt_q - 1'b1;
            end
            default: state_q <= AFC_IDLE;
         endcase
      end
   end
   assign sq.strobeN = (state_q != AFC_LOW);
   assign sq.busy = (state_q != AFC_IDLE);
   // count is the pulse length in cycles, 35 ns at 8 ns rounded up
   a_strobe_width: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(sq.strobeN) && clkEn |-> !sq.strobeN [*5])
      else $error("strobe low shorter than pulse time");
endmodule

// *** afc_host.sv ***
// host controller driving an 8k x 9 asynchronous fifo device through its pins
// assumes device flags arrive asynchronously; software uses the plain register port
`timescale 1ns/10ps
`include "afc_defs.svh"
module afc_host
   import afc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic [`AFC_ADDR_W-1:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   output logic write_n,
   output logic read_n,
   output logic [`AFC_WIDTH-1:0] write_bus,
   input wire logic [`AFC_WIDTH-1:0] read_bus,
   input wire logic empty_flag_n,
   input wire logic full_flag_n,
   input wire logic chain_token_out_or_half_flag,
   output logic first_load_or_replay,
   output logic reset_n
);
   afc_strobe_if wrIf();
   afc_strobe_if rdIf();
   logic [1:0] emptySync_q;
   logic [1:0] fullSync_q;
   logic [1:0] halfSync_q;
   logic chain_q;
   logic firstLoad_q;
   logic devReset_q;
   logic replay_q;
   logic [`AFC_WIDTH-1:0] wdata_q;
   logic [`AFC_WIDTH-1:0] rdata_q;
   logic [`AFC_WIDTH-1:0] wbus_q;
   logic [`AFC_WIDTH-1:0] rbusSync_q;
   logic wrapped_q;
   logic rdValid_q;
   logic wrPend_q;
   logic rdPend_q;
   logic wrLost_q;
   logic rdLost_q;
   logic [`AFC_PTR_W-1:0] count_q;
   logic [`AFC_PTR_W-1:0] wrPtr_q;
   logic rdEnd_q;
   logic devEmpty;
   logic devFull;
   logic devHalf;
   logic wrGo;
   logic rdGo;
   logic replayOk;
   logic [31:0] rdMux;

   afc_strobe_seq u_wr (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .sq(wrIf.seq));
   afc_strobe_seq u_rd (.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .sq(rdIf.seq));

   // two-flop synchronisers for the device flags
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         emptySync_q <= 2'h0;
         fullSync_q <= 2'h3;
         halfSync_q <= 2'h3;
      end
      else if (clkEn)
      begin
         emptySync_q <= {emptySync_q[0], empty_flag_n};
         fullSync_q <= {fullSync_q[0], full_flag_n};
         halfSync_q <= {halfSync_q[0], chain_token_out_or_half_flag};
      end
   end
   assign devEmpty = !emptySync_q[1];
   assign devFull = !fullSync_q[1];
   // half-full hidden when chained
   assign devHalf = !halfSync_q[1] && !chain_q;

   // control register: mode, first-load selection, device reset
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         chain_q <= 1'b0;
         firstLoad_q <= 1'b0;
         devReset_q <= 1'b1;
      end
      else if (clkEn && regWr && regAddr == `AFC_REG_CTRL)
      begin
         chain_q <= regWdata[`AFC_CTRL_CHAIN];
         firstLoad_q <= regWdata[`AFC_CTRL_FIRST];
         devReset_q <= regWdata[`AFC_CTRL_RESET];
      end
   end
   // device reset held while rstn low or bit set
   assign reset_n = !devReset_q;

   // writes only when the device is not full and sequencer idle
   assign wrGo = wrPend_q && !wrIf.busy && !devFull && !devReset_q;
   // reads only when the device is not empty
   assign rdGo = rdPend_q && !rdIf.busy && !devEmpty && !devReset_q && !replay_q;
   assign wrIf.start = wrGo;
   assign rdIf.start = rdGo;
   assign write_n = wrIf.strobeN;
   assign read_n = rdIf.strobeN;

   // write data register, nine bits to the bus
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wdata_q <= '0;
         wbus_q <= '0;
         wrPend_q <= 1'b0;
         wrLost_q <= 1'b0;
      end
      else if (clkEn)
      begin
         // bus word frozen for the whole strobe; queue register free again
         if (wrGo)
         begin
            wbus_q <= wdata_q;
            wrPend_q <= 1'b0;
         end
         if (regWr && regAddr == `AFC_REG_WDATA)
         begin
            wdata_q <= (wrPend_q && !wrGo) ? wdata_q : regWdata[`AFC_WIDTH-1:0];
            wrPend_q <= 1'b1;
            wrLost_q <= wrLost_q | (wrPend_q && !wrGo);
         end
         if (regWr && regAddr == `AFC_REG_STAT)
            wrLost_q <= 1'b0;
      end
   end
   // data and strobe only, no address leaves the host
   assign write_bus = wbus_q;

   // read word captured when the strobe rises, in device order
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rdata_q <= '0;
         rdValid_q <= 1'b0;
         rdPend_q <= 1'b0;
         rdLost_q <= 1'b0;
         rdEnd_q <= 1'b0;
         rbusSync_q <= '0;
      end
      else if (clkEn)
      begin
         rdEnd_q <= !rdIf.strobeN;
         rbusSync_q <= read_bus; // first stage for the async data pins
         if (rdEnd_q && rdIf.strobeN)
         begin
            rdata_q <= rbusSync_q;
            rdValid_q <= 1'b1;
         end
         else if (regRd && regAddr == `AFC_REG_RDATA)
            rdValid_q <= 1'b0;
         if (regWr && regAddr == `AFC_REG_RDATA)
            rdPend_q <= 1'b1;
         else if (rdGo)
            rdPend_q <= 1'b0;
         if (regWr && regAddr == `AFC_REG_RDATA && rdPend_q && !rdGo)
            rdLost_q <= 1'b1;
         else if (regWr && regAddr == `AFC_REG_STAT)
            rdLost_q <= 1'b0;
      end
   end

   // replay allowed only if the write pointer never wrapped, and never when chained
   assign replayOk = !chain_q && !wrapped_q;

   // replay pulse on the shared first-load pin
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         replay_q <= 1'b0;
      else if (clkEn)
         replay_q <= regWr && regAddr == `AFC_REG_CTRL && regWdata[`AFC_CTRL_REPLAY]
            && !regWdata[`AFC_CTRL_CHAIN] && replayOk && !rdIf.busy && !rdGo;
   end
   // chained: pin is first-load select; else idle-high replay strobe
   assign first_load_or_replay = chain_q ? !firstLoad_q : !replay_q;

   // occupancy tracking: count of words, write position since reset
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         count_q <= '0;
         wrPtr_q <= '0;
         wrapped_q <= 1'b0;
      end
      else if (clkEn)
      begin
         if (devReset_q)
         begin
            count_q <= '0;
            wrPtr_q <= '0;
            wrapped_q <= 1'b0;
         end
         else
         begin
            if (replay_q)
               count_q <= wrPtr_q + (wrGo ? 1'b1 : 1'b0);
            else if (wrGo && !rdGo)
               count_q <= count_q + 1'b1;
            else if (rdGo && !wrGo)
               count_q <= count_q - 1'b1;
            if (wrGo)
               wrPtr_q <= wrPtr_q + 1'b1;
            // sticky once the device write pointer passes its top location
            if (wrGo && wrPtr_q == `AFC_PTR_W'(`AFC_DEPTH - 1))
               wrapped_q <= 1'b1;
         end
      end
   end

   // register read mux, data in the next cycle
   always_comb
   begin
      rdMux = '0;
      case (regAddr)
         `AFC_REG_CTRL: rdMux = {28'h0000_000, 1'b0, devReset_q, firstLoad_q, chain_q};
         `AFC_REG_STAT: rdMux = {24'h00_0000, rdLost_q, wrLost_q, rdValid_q, rdPend_q,
            wrPend_q, devHalf, devFull, devEmpty};
         `AFC_REG_RDATA: rdMux = {23'h00_0000, rdata_q};
         `AFC_REG_COUNT: rdMux = {18'h0_0000, count_q};
         default: rdMux = '0;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         regRdata <= '0;
      else if (clkEn)
         regRdata <= regRd ? rdMux : '0;
   end

   a_write_not_full: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(write_n) |-> $past(fullSync_q[1]))
      else $error("write strobe started while device full");
   a_read_not_empty: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(read_n) |-> $past(emptySync_q[1]))
      else $error("read strobe started while device empty");
   a_replay_chain: assert property (@(posedge clk_sys) disable iff (!rstn)
      chain_q |-> !replay_q && first_load_or_replay == !firstLoad_q)
      else $error("replay driven in chained mode");
   a_reset_pin: assert property (@(posedge clk_sys) disable iff (!rstn)
      devReset_q |-> write_n && read_n)
      else $error("strobe during device reset");
endmodule

// *** afc_dev_model.sv ***
// behavioural model of the 9-bit asynchronous fifo device on the host pins
// assumes standalone mode; DEPTH may be shortened to reach full quickly
`timescale 1ns/10ps
`include "afc_defs.svh"
module afc_dev_model
#(
   parameter int DEPTH = `AFC_DEPTH
)
(
   input wire logic write_n,
   input wire logic read_n,
   input wire logic [`AFC_WIDTH-1:0] write_bus,
   output logic [`AFC_WIDTH-1:0] read_bus,
   output logic empty_flag_n,
   output logic full_flag_n,
   output logic chain_token_out_or_half_flag,
   input wire logic first_load_or_replay,
   input wire logic reset_n
);
   logic [`AFC_WIDTH-1:0] mem [DEPTH];
   int wp = 0;
   int rp = 0;
   int cnt = 0;
   assign empty_flag_n = (cnt != 0);
   assign full_flag_n = (cnt != DEPTH);
   assign chain_token_out_or_half_flag = !(cnt > DEPTH / 2);
   initial read_bus = '0;
   always @(negedge reset_n)
   begin
      wp = 0;
      rp = 0;
      cnt = 0;
   end
   // store on write rising edge, refused when full
   always @(posedge write_n)
      if (reset_n && cnt < DEPTH)
      begin
         mem[wp] = write_bus;
         wp = (wp + 1) % DEPTH;
         cnt++;
      end
   // oldest word out, no pointer move while empty
   always @(negedge read_n)
      if (reset_n && cnt > 0)
         read_bus = mem[rp];
   always @(posedge read_n)
      if (reset_n && cnt > 0)
      begin
         rp = (rp + 1) % DEPTH;
         cnt--;
      end
   // replay rewinds read pointer, write pointer kept
   always @(negedge first_load_or_replay)
      if (reset_n)
      begin
         rp = 0;
         cnt = wp;
      end
endmodule

// *** tb_afc_host.sv ***
// self-checking bench for the fifo host controller against a device model
// assumes a 125 MHz clk_sys and a model depth of 16 words
`timescale 1ns/10ps
`include "afc_defs.svh"
module tb_afc_host
   import afc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic clkEn = 1'b1;
   logic [`AFC_ADDR_W-1:0] regAddr = '0;
   logic [31:0] regWdata = '0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [31:0] regRdata;
   logic write_n;
   logic read_n;
   logic [`AFC_WIDTH-1:0] write_bus;
   logic [`AFC_WIDTH-1:0] read_bus;
   logic empty_flag_n;
   logic full_flag_n;
   logic chain_token_out_or_half_flag;
   logic first_load_or_replay;
   logic reset_n;
   logic [31:0] rv;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   // clock and instances
   always #4 clk_sys = !clk_sys;
   afc_host afc_host_inst (.clk_sys, .rstn, .clkEn, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .write_n, .read_n, .write_bus, .read_bus, .empty_flag_n, .full_flag_n,
      .chain_token_out_or_half_flag, .first_load_or_replay, .reset_n);
   afc_dev_model #(.DEPTH(16)) afc_dev_model_inst (.write_n, .read_n, .write_bus, .read_bus,
      .empty_flag_n, .full_flag_n, .chain_token_out_or_half_flag, .first_load_or_replay,
      .reset_n);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   // poll one status bit under a bounded count
   task automatic waitStat(input int b, input logic v);
      logic [31:0] s;
      for (int i = 0; i < 100; i++)
      begin
         rd(`AFC_REG_STAT, s);
         if (s[b] === v)
            return;
      end
      failures++;
      $display("CHECK FAILED t=%0t status wait", $time);
   endtask
   task automatic put(input logic [8:0] d);
      wr(`AFC_REG_WDATA, {23'h0, d});
      waitStat(3, 1'b0);
   endtask
   task automatic get(input logic [8:0] e);
      wr(`AFC_REG_RDATA, 32'h0);
      waitStat(5, 1'b1);
      rd(`AFC_REG_RDATA, rv);
      chk(rv, {23'h0, e});
   endtask
   task automatic t_reset();
      rd(`AFC_REG_CTRL, rv);
      chk(rv, 32'h4);
      chk(reset_n, 1'b0);
      rd(`AFC_REG_STAT, rv);
      chk(rv, 32'h1);
      wr(`AFC_REG_CTRL, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk(reset_n, 1'b1);
      rd(4'hf, rv);
      chk(rv, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_order_replay();
      put(9'h1ff);
      put(9'h100);
      put(9'h055);
      rd(`AFC_REG_COUNT, rv);
      chk(rv, 32'h3);
      get(9'h1ff);
      get(9'h100);
      get(9'h055);
      // three words only, so neither pointer wraps while replaying
      for (int k = 0; k < 2; k++)
      begin
         wr(`AFC_REG_CTRL, 32'h8);
         waitStat(0, 1'b0);
         rd(`AFC_REG_COUNT, rv);
         chk(rv, 32'h3);
         get(9'h1ff);
         get(9'h100);
         get(9'h055);
      end
      $display("order and replay test done");
   endtask
   task automatic t_empty();
      wr(`AFC_REG_RDATA, 32'h0);
      wr(`AFC_REG_RDATA, 32'h0);
      repeat (20) @(posedge clk_sys);
      chk(read_n, 1'b1);
      rd(`AFC_REG_STAT, rv);
      chk(rv, 32'h91);
      wr(`AFC_REG_STAT, 32'h0);
      put(9'h0aa);
      waitStat(5, 1'b1);
      rd(`AFC_REG_RDATA, rv);
      chk(rv, 32'h0aa);
      rd(`AFC_REG_STAT, rv);
      chk(rv, 32'h1);
      $display("empty test done");
   endtask
   task automatic t_full();
      for (int i = 0; i < 16; i++)
         put(i[8:0]);
      wr(`AFC_REG_WDATA, 32'h1ee);
      wr(`AFC_REG_WDATA, 32'h1dd);
      repeat (20) @(posedge clk_sys);
      chk(write_n, 1'b1);
      rd(`AFC_REG_STAT, rv);
      chk(rv, 32'h4e);
      wr(`AFC_REG_STAT, 32'h0);
      wr(`AFC_REG_CTRL, 32'h1);
      rd(`AFC_REG_STAT, rv);
      chk(rv[2], 1'b0);
      chk(rv[6], 1'b0);
      wr(`AFC_REG_CTRL, 32'h0);
      get(9'h000);
      waitStat(3, 1'b0);
      for (int i = 1; i < 16; i++)
         get(i[8:0]);
      get(9'h1ee);
      rd(`AFC_REG_COUNT, rv);
      chk(rv, 32'h0);
      $display("full test done");
   endtask
   task automatic t_chain();
      wr(`AFC_REG_CTRL, 32'h1);
      wr(`AFC_REG_CTRL, 32'h9);
      repeat (4)
      begin
         @(posedge clk_sys);
         chk(first_load_or_replay, 1'b1);
      end
      rd(`AFC_REG_COUNT, rv);
      chk(rv, 32'h0);
      wr(`AFC_REG_CTRL, 32'h3);
      repeat (3) @(posedge clk_sys);
      chk(first_load_or_replay, 1'b0);
      clkEn <= 1'b0;
      wr(`AFC_REG_CTRL, 32'h0);
      clkEn <= 1'b1;
      rd(`AFC_REG_CTRL, rv);
      chk(rv, 32'h3);
      $display("chain test done");
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // cycle ceiling against a hang
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         stop_test();
      end
   end
   // main sequence
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset();
      t_order_replay();
      t_empty();
      t_full();
      t_chain();
      stop_test();
   end
endmodule
